// file: rtl/sts_pkg.sv
/*
  Constants, register map and types shared by the self test scheduler and
  status indicator logic. Assumes a 20 MHz core clock.
*/
package sts_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_INTERVAL  = 8'h04;
  localparam logic [7:0] A_DURATION  = 8'h08;
  localparam logic [7:0] A_COUNTDOWN = 8'h0C;
  localparam logic [7:0] A_STATUS    = 8'h10;
  localparam logic [7:0] A_INT_STAT  = 8'h14;
  localparam logic [7:0] A_INT_MASK  = 8'h18;
  localparam logic [7:0] A_SB_TIME   = 8'h1C;
  localparam logic [7:0] A_SB_EVENTS = 8'h20;

  // Control register bits
  localparam int CTRL_START   = 0;
  localparam int CTRL_STOP    = 1;
  localparam int CTRL_INHIBIT = 2;
  localparam int CTRL_WIDE    = 3;

  // Interrupt status and mask bits
  localparam int IRQ_PASS = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_SKIP = 2;
  localparam int IRQ_W    = 3;

  // Reset values
  localparam logic [7:0]  INTERVAL_RST = 8'h1E;
  localparam logic [15:0] DURATION_RST = 16'h012C;

  // Frequency tolerance bands in hertz
  localparam logic [3:0] BAND_NARROW_HZ = 4'h3;
  localparam logic [3:0] BAND_WIDE_HZ   = 4'h6;

  // Time base
  localparam int CLK_HZ     = 20_000_000;
  localparam int SEC_CYC    = CLK_HZ;
  localparam int FLASH_MS   = 500;
  localparam int FLASH_CYC  = CLK_HZ / 1000 * FLASH_MS;
  localparam int DAY_S      = 86_400;
  localparam int WEEK_DAYS  = 7;
  localparam int MIN_PASS_S = 60;

  typedef enum logic [1:0] {st_idle, st_check, st_run} sts_state_e;

endpackage : sts_pkg

// file: rtl/sts_tick.sv
/*
  Free running divider giving a one-cycle enable pulse every DIV cycles.
  Assumes a single clock and an asynchronous active high reset.
*/
`timescale 1ns/1ps
module sts_tick #(
  parameter int DIV = 2
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt;
  wire           last = (cnt == CW'(DIV - 1));

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt    <= last ? '0 : cnt + 1'b1;
      tick_o <= last;
    end
  end
endmodule : sts_tick

// file: rtl/sts_rise.sv
/*
  Rising edge detector on a synchronous level.
  Assumes the input is already synchronous to the core clock.
*/
`timescale 1ns/1ps
module sts_rise (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      rise_o
);
  logic q;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= 1'b0;
    else
      q <= d_i;
  end

  assign rise_o = d_i & ~q;
endmodule : sts_rise

// file: rtl/sts_top.sv
/*
  Self test scheduler and front panel status indicators with APB registers.
  Assumes synchronous key, alarm and sensor inputs and a 20 MHz core clock.
*/
// Decided for this implementation: register access over APB and the register addresses.
//
// Contract
// - Green lit normally, flashing on minor alarm, off on major alarm.
// - Red flashes only while a major alarm exists, else off.
// - Enter plus down chord starts a test when idle, halts a running one.
// - Test first checks battery present and charged, else skips inverter.
// - Test then runs standby for duration; passes if battery and output held.
// - Failure latches fail alarm; cleared by a pass lasting a minute or more.
// - Menu and status card may start or stop a test at any time.
// - Inhibit cancels only an automatic test due within seven days.
// - Repeated inhibit pushes next auto test seven days past latest one.
// - Manual tests run regardless of inhibit deferral.
// - Auto test on by default every 30 days; interval zero disables.
// - Countdown to the next automatic test is kept and readable.
// - Standby duration is adjustable and shared by auto and manual tests.
// - Standby time and event counters frozen during a self test.
// - Frequency tolerance 3 Hz or 6 Hz; transfer only outside band.
// - No battery transfer while battery at or below low voltage cutoff.
// - Test fails on output failure or battery below cell threshold.
`timescale 1ns/1ps
module sts_top #(
  parameter int SEC_CYC   = sts_pkg::SEC_CYC,
  parameter int FLASH_CYC = sts_pkg::FLASH_CYC,
  parameter int DAY_S     = sts_pkg::DAY_S
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        enter_key_i,
  input  wire logic        down_key_i,
  input  wire logic        card_start_i,
  input  wire logic        card_stop_i,
  input  wire logic        card_inhibit_i,
  input  wire logic        major_alarm_i,
  input  wire logic        minor_alarm_i,
  input  wire logic        batt_present_i,
  input  wire logic        batt_charged_i,
  input  wire logic        batt_above_cell_i,
  input  wire logic        batt_above_lvc_i,
  input  wire logic        output_ok_i,
  input  wire logic        input_lost_i,
  input  wire logic [3:0]  freq_dev_hz_i,
  output logic             green_led_o,
  output logic             red_led_o,
  output logic             on_batt_o,
  output logic             test_run_o,
  output logic             fail_alarm_o,
  output logic             irq_o
);
  localparam logic [31:0] WEEK_S = 32'(sts_pkg::WEEK_DAYS * DAY_S);

  sts_pkg::sts_state_e state;
  sts_pkg::sts_state_e next_state;
  logic [7:0]             interval;
  logic [15:0]            duration;
  logic [15:0]            run_s;
  logic [31:0]            countdown;
  logic [31:0]            next_countdown;
  logic [31:0]            sb_time;
  logic [31:0]            sb_events;
  logic [sts_pkg::IRQ_W-1:0] int_stat;
  logic [sts_pkg::IRQ_W-1:0] int_mask;
  logic                   ctrl_wide;
  logic                   flash;
  logic                   fail_latch;
  logic                   sec_tick;
  logic                   flash_tick;
  logic                   chord_rise;
  logic                   sb_rise;
  logic                   line_batt;

  sts_tick #(.DIV(SEC_CYC)) u_sec (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (sec_tick)
  );

  sts_tick #(.DIV(FLASH_CYC)) u_flash (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (flash_tick)
  );

  // Edge on the chord, so a held pair of keys acts once
  wire chord = enter_key_i & down_key_i;
  sts_rise u_chord (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (chord),
    .rise_o     (chord_rise)
  );

  // APB decode; zero wait states
  wire setup    = psel_i & ~penable_i;
  wire access   = psel_i & penable_i;
  wire sel_ctrl = (paddr_i == sts_pkg::A_CTRL);
  wire sel_int  = (paddr_i == sts_pkg::A_INTERVAL);
  wire sel_dur  = (paddr_i == sts_pkg::A_DURATION);
  wire sel_cnt  = (paddr_i == sts_pkg::A_COUNTDOWN);
  wire sel_stat = (paddr_i == sts_pkg::A_STATUS);
  wire sel_ist  = (paddr_i == sts_pkg::A_INT_STAT);
  wire sel_imsk = (paddr_i == sts_pkg::A_INT_MASK);
  wire sel_sbt  = (paddr_i == sts_pkg::A_SB_TIME);
  wire sel_sbe  = (paddr_i == sts_pkg::A_SB_EVENTS);
  wire hit      = sel_ctrl | sel_int | sel_dur | sel_cnt | sel_stat | sel_ist
                | sel_imsk | sel_sbt | sel_sbe;
  wire wr       = access & pwrite_i & hit;
  wire wr_ctrl  = wr & sel_ctrl;
  wire wr_int   = wr & sel_int;

  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~hit;

  wire busy      = (state != sts_pkg::st_idle);
  wire running   = (state == sts_pkg::st_run);
  wire menu_start = wr_ctrl & pwdata_i[sts_pkg::CTRL_START];
  wire menu_stop  = wr_ctrl & pwdata_i[sts_pkg::CTRL_STOP];
  wire inhibit    = (wr_ctrl & pwdata_i[sts_pkg::CTRL_INHIBIT]) | card_inhibit_i;

  wire [31:0] st_word = {28'h0, on_batt_o, fail_latch, running, busy};
  wire [31:0] rd_mux  =
      sel_ctrl ? {28'h0, ctrl_wide, 3'h0} :
      sel_int  ? {24'h0, interval} :
      sel_dur  ? {16'h0, duration} :
      sel_cnt  ? countdown :
      sel_stat ? st_word :
      sel_ist  ? {29'h0, int_stat} :
      sel_imsk ? {29'h0, int_mask} :
      sel_sbt  ? sb_time :
      sel_sbe  ? sb_events : 32'h0;

  // Manual sources take effect regardless of inhibit deferral
  wire man_start = (chord_rise & ~busy) | menu_start | card_start_i;
  wire stop_req  = (chord_rise & busy) | menu_stop | card_stop_i;

  // Automatic schedule in seconds
  wire auto_en   = (interval != 8'h00);
  wire [31:0] reload = 32'(interval * DAY_S);
  wire inh_hit   = inhibit & auto_en & (countdown <= WEEK_S);
  wire auto_due  = auto_en & sec_tick & (countdown == 32'h1) & ~inhibit & ~wr_int;

  assign next_countdown =
      wr_int                          ? 32'(pwdata_i[7:0] * DAY_S) :
      inh_hit                         ? WEEK_S :
      (inhibit | ~auto_en | ~sec_tick) ? countdown :
      auto_due                        ? reload :
      countdown - 32'h1;

  // Test sequence
  wire batt_ok    = batt_present_i & batt_charged_i;
  wire fault      = ~batt_above_cell_i | ~output_ok_i;
  wire [15:0] run_next = run_s + 16'h1;
  wire done       = running & sec_tick & (run_next >= duration);
  wire ev_skip    = (state == sts_pkg::st_check) & ~batt_ok;
  wire ev_fail    = (running & fault & ~stop_req) | ev_skip;
  wire ev_pass    = done & ~fault & ~stop_req;
  wire long_pass  = ev_pass & (run_next >= 16'(sts_pkg::MIN_PASS_S));

  always_comb
  begin
    next_state = state;
    unique case (state)
      sts_pkg::st_idle:
        if (man_start | auto_due)
          next_state = sts_pkg::st_check;
      sts_pkg::st_check:
        if (stop_req | ~batt_ok)
          next_state = sts_pkg::st_idle;
        else
          next_state = sts_pkg::st_run;
      sts_pkg::st_run:
        if (stop_req | fault | done)
          next_state = sts_pkg::st_idle;
      default:
        next_state = sts_pkg::st_idle;
    endcase
  end

  // Line side: frequency band and low voltage cutoff
  wire [3:0] band   = ctrl_wide ? sts_pkg::BAND_WIDE_HZ : sts_pkg::BAND_NARROW_HZ;
  wire out_band     = (freq_dev_hz_i > band);
  wire outage       = input_lost_i | out_band;
  wire next_on_batt = (outage | running) & batt_present_i & batt_above_lvc_i;
  // Line-driven transfer only, so the cycle after a test never counts
  wire sb_live      = line_batt & ~busy;

  sts_rise u_sb (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (sb_live),
    .rise_o     (sb_rise)
  );

  wire [sts_pkg::IRQ_W-1:0] ev_vec = {ev_skip, ev_fail, ev_pass};
  wire [sts_pkg::IRQ_W-1:0] ist_clr = (wr & sel_ist) ? pwdata_i[sts_pkg::IRQ_W-1:0] : '0;
  wire [sts_pkg::IRQ_W-1:0] next_irq_stat = (int_stat & ~ist_clr) | ev_vec;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state     <= sts_pkg::st_idle;
      interval  <= sts_pkg::INTERVAL_RST;
      duration  <= sts_pkg::DURATION_RST;
      ctrl_wide <= 1'b0;
      int_mask  <= '0;
      int_stat  <= '0;
      countdown <= 32'(sts_pkg::INTERVAL_RST * DAY_S);
      prdata_o  <= 32'h0;
    end
    else
    begin
      state     <= next_state;
      countdown <= next_countdown;
      int_stat  <= (int_stat & ~ist_clr) | ev_vec; // Set wins over clear
      if (setup)
        prdata_o <= rd_mux;
      if (wr_int)
        interval <= pwdata_i[7:0];
      if (wr & sel_dur)
        duration <= pwdata_i[15:0];
      if (wr_ctrl)
        ctrl_wide <= pwdata_i[sts_pkg::CTRL_WIDE];
      if (wr & sel_imsk)
        int_mask <= pwdata_i[sts_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_s      <= 16'h0;
      fail_latch <= 1'b0;
      sb_time    <= 32'h0;
      sb_events  <= 32'h0;
      on_batt_o  <= 1'b0;
      line_batt  <= 1'b0;
      flash      <= 1'b0;
    end
    else
    begin
      run_s      <= ~running ? 16'h0 : (sec_tick ? run_next : run_s);
      fail_latch <= ev_fail | (fail_latch & ~long_pass);
      on_batt_o  <= next_on_batt;
      line_batt  <= outage & batt_present_i & batt_above_lvc_i;
      if (sec_tick & sb_live)
        sb_time <= sb_time + 32'h1;
      if (sb_rise)
        sb_events <= sb_events + 32'h1;
      if (flash_tick)
        flash <= ~flash;
    end
  end

  // Major alarm takes precedence over minor on both indicators
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      green_led_o <= 1'b0;
      red_led_o   <= 1'b0;
      irq_o       <= 1'b0;
    end
    else
    begin
      green_led_o <= major_alarm_i ? 1'b0 : (minor_alarm_i ? flash : 1'b1);
      red_led_o   <= major_alarm_i & flash;
      irq_o       <= |(next_irq_stat & int_mask);
    end
  end

  assign test_run_o   = running;
  assign fail_alarm_o = fail_latch;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_green_major: assert property (major_alarm_i |=> !green_led_o)
    else $error("green lit under major alarm");
  a_green_normal: assert property (!major_alarm_i && !minor_alarm_i |=> green_led_o)
    else $error("green not solid in normal operation");
  a_red_quiet: assert property (!major_alarm_i |=> !red_led_o)
    else $error("red lit without major alarm");
  a_red_flash: assert property (major_alarm_i && flash |=> red_led_o)
    else $error("red not following flash under major alarm");
  a_chord_start: assert property (state == sts_pkg::st_idle && chord_rise
    |=> state == sts_pkg::st_check)
    else $error("chord did not start a test");
  a_chord_halt: assert property (running && chord_rise |=> state == sts_pkg::st_idle)
    else $error("chord did not halt the test");
  a_hold_once: assert property (chord && $past(chord) |-> !chord_rise)
    else $error("held chord retriggered");
  a_batt_skip: assert property (state == sts_pkg::st_check && !batt_ok
    |=> state == sts_pkg::st_idle ##1 !on_batt_o || outage)
    else $error("inverter entered without charged battery");
  a_fault_latch: assert property (running && fault |=> fail_latch
    && state == sts_pkg::st_idle)
    else $error("fault did not latch fail alarm");
  a_short_keep: assert property (fail_latch && ev_pass && !long_pass |=> fail_latch)
    else $error("short pass cleared fail alarm");
  a_inhibit_cap: assert property (inh_hit && !wr_int |=> countdown == WEEK_S)
    else $error("inhibit did not defer by a week");
  a_inhibit_far: assert property (inhibit && !inh_hit && !wr_int
    |=> countdown == $past(countdown))
    else $error("inhibit moved a distant test");
  a_auto_off: assert property (interval == 8'h00 && !busy && !man_start |=> !busy)
    else $error("auto test with interval zero");
  a_manual_go: assert property (!busy && man_start |=> busy)
    else $error("manual start refused");
  a_sb_frozen: assert property (busy |=> sb_time == $past(sb_time))
    else $error("standby time advanced during test");
  a_lvc_block: assert property (!batt_above_lvc_i |=> !on_batt_o)
    else $error("battery transfer below cutoff");
  a_in_band: assert property (!input_lost_i && !out_band && !running |=> !on_batt_o)
    else $error("transfer while input in band");

  c_pass: cover property (ev_pass);
  c_fail: cover property (running && fault);
  c_inhibit: cover property (inh_hit);
  c_skip: cover property (ev_skip);
  c_auto: cover property (auto_due && state == sts_pkg::st_idle);

endmodule : sts_top

// file: verif/sts_panel.sv
/*
  Keypad and status card model facing sts_top.
  Assumes one core clock; all lines idle low between commands.
*/
`timescale 1ns/1ps
module sts_panel (
  input  wire logic core_clk_i,
  output logic      enter_key_o,
  output logic      down_key_o,
  output logic      card_start_o,
  output logic      card_stop_o,
  output logic      card_inhibit_o
);
  initial
  begin
    enter_key_o    = 1'b0;
    down_key_o     = 1'b0;
    card_start_o   = 1'b0;
    card_stop_o    = 1'b0;
    card_inhibit_o = 1'b0;
  end

  // Keys land a cycle apart, as real fingers do
  task chord(input int hold);
    @(posedge core_clk_i);
    enter_key_o <= 1'b1;
    @(posedge core_clk_i);
    down_key_o <= 1'b1;
    repeat (hold) @(posedge core_clk_i);
    enter_key_o <= 1'b0;
    down_key_o  <= 1'b0;
  endtask : chord

  // One-cycle pulses: 0 start, 1 stop, 2 inhibit
  task card(input int c);
    @(posedge core_clk_i);
    card_start_o   <= (c == 0);
    card_stop_o    <= (c == 1);
    card_inhibit_o <= (c == 2);
    @(posedge core_clk_i);
    card_start_o   <= 1'b0;
    card_stop_o    <= 1'b0;
    card_inhibit_o <= 1'b0;
  endtask : card
endmodule : sts_panel

// file: verif/sts_tb.sv
/*
  Bench for sts_top: alarm and transfer table, then self test cases.
  Assumes sts_panel plays keypad and card; time base shortened.
*/
`timescale 1ns/1ps
module self_test_scheduler_status_leds_tb_top;
  // Major, minor, lost, lvc, freq, wide, on_batt, green, red; 2 lit 1 dark 3 flash
  localparam logic [13:0] ROWS [10] = '{14'h0409, 14'h140D, 14'h2407,
    14'h3407, 14'h0519, 14'h0529, 14'h05F9, 14'h04C9, 14'h0C19, 14'h0809};
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        maj = 1'b0;
  logic        mnr = 1'b0;
  logic        bc = 1'b1;
  logic        bp = 1'b1;
  logic        bac = 1'b1;
  logic        ook = 1'b1;
  logic        lost = 1'b0;
  logic        lvc = 1'b1;
  logic [3:0]  fdev = 4'h0;
  logic [31:0] prdata, rd, t0, e0;
  logic        pready, pslverr, err, ent, dwn, cst, csp, cinh;
  logic        green, red, onb, run, fal, irq;
  logic [13:0] row;
  logic [1:0]  gs, rs;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;

  always #25 core_clk = ~core_clk;

  sts_top #(.SEC_CYC(10), .FLASH_CYC(4), .DAY_S(20)) u_dut (
    .core_clk_i(core_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .enter_key_i(ent), .down_key_i(dwn),
    .card_start_i(cst), .card_stop_i(csp), .card_inhibit_i(cinh),
    .major_alarm_i(maj), .minor_alarm_i(mnr), .batt_present_i(bp),
    .batt_charged_i(bc), .batt_above_cell_i(bac), .batt_above_lvc_i(lvc),
    .output_ok_i(ook), .input_lost_i(lost), .freq_dev_hz_i(fdev),
    .green_led_o(green), .red_led_o(red), .on_batt_o(onb), .test_run_o(run),
    .fail_alarm_o(fal), .irq_o(irq));

  sts_panel u_panel (.core_clk_i(core_clk), .enter_key_o(ent), .down_key_o(dwn),
    .card_start_o(cst), .card_stop_o(csp), .card_inhibit_o(cinh));

  task wrap_up();
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Waits as long as the slave asks; only the hang guard ends it
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_run(input logic v, input int lim);
    n = 0;
    while (run !== v && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("run", run, v);
  endtask : wait_run

  // Hang guard, far above the roughly 1600 cycles needed
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    apb(0, sts_pkg::A_INTERVAL, 0);
    chk("interval", rd, 32'h1E);
    apb(0, sts_pkg::A_DURATION, 0);
    chk("duration", rd, 32'h12C);
    apb(0, sts_pkg::A_COUNTDOWN, 0);
    chk("countdown", rd > 590 && rd <= 600, 1'b1);
    apb(0, 8'h40, 0);
    chk("bad_addr", {err, rd[30:0]}, 32'h80000000);
    chk("pready", pready, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      row = ROWS[i];
      maj  <= row[13];
      mnr  <= row[12];
      lost <= row[11];
      lvc  <= row[10];
      fdev <= row[9:6];
      apb(1, sts_pkg::A_CTRL, {28'h0, row[5], 3'h0});
      repeat (4) @(posedge core_clk);
      gs = 2'h0;
      rs = 2'h0;
      repeat (10)
      begin
        @(posedge core_clk);
        gs = gs | {green, ~green};
        rs = rs | {red, ~red};
      end
      chk("green", gs, row[3:2]);
      chk("red", rs, row[1:0]);
      chk("on_batt", onb, row[4]);
    end
    lost <= 1'b0;
    lvc  <= 1'b1;
    apb(1, sts_pkg::A_INT_MASK, 32'h7);
    apb(1, sts_pkg::A_DURATION, 32'h3);
    apb(0, sts_pkg::A_SB_TIME, 0);
    t0 = rd;
    apb(0, sts_pkg::A_SB_EVENTS, 0);
    e0 = rd;
    // Keys held well past the start must not stop the test
    fork
      u_panel.chord(12);
    join_none
    wait_run(1'b1, 8);
    wait_run(1'b0, 60);
    chk("length", n >= 18 && n <= 33, 1'b1);
    apb(0, sts_pkg::A_INT_STAT, 0);
    chk("int_pass", rd, 32'h1);
    chk("irq", irq, 1'b1);
    apb(0, sts_pkg::A_SB_TIME, 0);
    chk("sb_time", rd, t0);
    apb(0, sts_pkg::A_SB_EVENTS, 0);
    chk("sb_events", rd, e0);
    apb(1, sts_pkg::A_INT_STAT, 32'h7);
    apb(1, sts_pkg::A_INT_MASK, 32'h1);
    chk("irq_clr", irq, 1'b0);
    u_panel.card(0);
    wait_run(1'b1, 6);
    ook <= 1'b0;
    wait_run(1'b0, 4);
    chk("fail", fal, 1'b1);
    apb(0, sts_pkg::A_INT_STAT, 0);
    chk("int_fail", rd, 32'h2);
    chk("irq_mask", irq, 1'b0);
    ook <= 1'b1;
    u_panel.card(0);
    wait_run(1'b1, 6);
    // Cell voltage sag alone must end the test early
    bac <= 1'b0;
    wait_run(1'b0, 4);
    bac <= 1'b1;
    u_panel.card(0);
    wait_run(1'b1, 6);
    wait_run(1'b0, 60);
    chk("fail_short", fal, 1'b1);
    apb(1, sts_pkg::A_DURATION, 32'd60);
    apb(1, sts_pkg::A_CTRL, 32'h1);
    wait_run(1'b1, 6);
    wait_run(1'b0, 650);
    chk("fail_clr", fal, 1'b0);
    fork
      u_panel.chord(3);
    join_none
    wait_run(1'b1, 6);
    repeat (6) @(posedge core_clk);
    fork
      u_panel.chord(3);
    join_none
    wait_run(1'b0, 8);
    apb(1, sts_pkg::A_CTRL, 32'h1);
    wait_run(1'b1, 6);
    apb(1, sts_pkg::A_CTRL, 32'h2);
    wait_run(1'b0, 4);
    bc <= 1'b0;
    u_panel.chord(3);
    repeat (6) @(posedge core_clk);
    chk("no_run", run, 1'b0);
    chk("no_inv", onb, 1'b0);
    apb(0, sts_pkg::A_INT_STAT, 0);
    chk("skip", rd[2], 1'b1);
    bc <= 1'b1;
    apb(1, sts_pkg::A_INT_STAT, 32'h4);
    bp <= 1'b0;
    u_panel.chord(3);
    repeat (6) @(posedge core_clk);
    chk("no_batt", run, 1'b0);
    apb(0, sts_pkg::A_INT_STAT, 0);
    chk("skip_nb", rd[2], 1'b1);
    bp <= 1'b1;
    u_panel.card(2);
    apb(0, sts_pkg::A_COUNTDOWN, 0);
    chk("inh_far", rd > 140, 1'b1);
    apb(1, sts_pkg::A_INTERVAL, 32'h5);
    apb(1, sts_pkg::A_CTRL, 32'h4);
    apb(0, sts_pkg::A_COUNTDOWN, 0);
    chk("inh_near", rd >= 138 && rd <= 140, 1'b1);
    repeat (50) @(posedge core_clk);
    u_panel.card(2);
    apb(0, sts_pkg::A_COUNTDOWN, 0);
    chk("inh_again", rd >= 138 && rd <= 140, 1'b1);
    u_panel.chord(3);
    wait_run(1'b1, 6);
    u_panel.card(1);
    wait_run(1'b0, 4);
    apb(1, sts_pkg::A_INTERVAL, 32'h1);
    wait_run(1'b1, 260);
    u_panel.card(1);
    wait_run(1'b0, 4);
    apb(1, sts_pkg::A_INTERVAL, 32'h0);
    repeat (300) @(posedge core_clk);
    chk("auto_off", run, 1'b0);
    // Reset while idle: settings and latched alarm return to defaults
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rst_green", green, 1'b1);
    chk("rst_fail", fal, 1'b0);
    apb(0, sts_pkg::A_INTERVAL, 0);
    chk("rst_interval", rd, 32'h1E);
    wrap_up();
  end
endmodule : self_test_scheduler_status_leds_tb_top
